// File: include/ddps_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts for
 * the dual data pointer select block.
 * Assumes byte-addressed Wishbone with one 32-bit word per register.
 */
`ifndef DDPS_REGS_SVH
`define DDPS_REGS_SVH

// Printed offsets are not all multiples of four: byte address = 4 * index
`define DDPS_AUX_IDX        8'hA2
`define DDPS_CLK_IDX        8'hAF
`define DDPS_DPTR0_IDX      8'hC0
`define DDPS_DPTR1_IDX      8'hC1
`define DDPS_MODE_IDX       8'hC2

`define DDPS_AUX_SEL_BIT    0
`define DDPS_AUX_ZERO_BIT   2
`define DDPS_AUX_FLAG_BIT   3
`define DDPS_AUX_BOOT_BIT   5
`define DDPS_CLK_SPI_BIT    0
`define DDPS_MODE_X2_BIT    0

`define DDPS_AUX_RESET      8'h00
`define DDPS_CLK_RESET      8'h00
`define DDPS_PTR_RESET      16'h0000

`define DDPS_BOOT_BASE      16'hF800
`define DDPS_CLK_FAST       4'h6
`define DDPS_CLK_SLOW       4'hC

`endif

// File: include/ddps_pkg.sv
/*
 * Types shared by the dual data pointer select block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ddps_pkg;

    typedef struct packed {
        logic        boot_rom_map_en;
        logic        user_flag_three;
        logic        pointer_select;
    } ddps_aux_t;

    typedef struct packed {
        logic [15:0] ptr0;
        logic [15:0] ptr1;
    } ddps_ptrs_t;

endpackage

// File: design/ddps_top.sv
/*
 * Dual data pointer select, boot ROM map enable and SPI clock-rate select,
 * all reachable as a classic Wishbone slave with one word per register.
 * Assumes a single 20 MHz clock and an asynchronous active-low reset; the
 * core drives pointer load/increment and the aux increment directly; the double-speed level is written over the bus.
 */
// Added by the designer: the Wishbone register port.
// Functional notes
// - Two 16-bit data pointers; select bit zero of aux register picks one.
// - Select zero uses first pointer, select one uses the second.
// - Boot enable set maps boot ROM over F800h to FFFFh, else unmapped.
// - Aux bit three is a plain read/write user flag with no effect.
// - Aux bit two always reads zero.
// - Increment of aux register toggles select, leaving the user flag alone.
// - Reserved aux bits may read any value; here they read zero.
// - Reset clears select; bit two reads zero after reset.
// - Reset clears the SPI rate select bit.
// - Double-speed gives 6 clocks per machine cycle, else 12; gates peripheral bits.
`timescale 1ns/1ps
`default_nettype none
`include "ddps_regs.svh"

module ddps_top
    import ddps_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        aux_inc_i,
    input  wire logic        ptr_load_i,
    input  wire logic [15:0] ptr_load_val_i,
    input  wire logic        ptr_inc_i,
    input  wire logic [15:0] code_addr_i,
    output logic      [15:0] data_pointer_o,
    output logic             boot_rom_map_en_o,
    output logic             boot_rom_hit_o,
    output logic             cpu_double_speed_o,
    output logic      [3:0]  cpu_clocks_per_cycle_o,
    output logic      [3:0]  spi_clocks_per_cycle_o
);

    ddps_aux_t   aux_q;
    ddps_aux_t   aux_d;
    ddps_ptrs_t  ptrs_q;
    ddps_ptrs_t  ptrs_d;
    logic        spi_rate_select_q;
    logic        spi_rate_select_d;
    logic        cpu_double_speed_q;
    logic        cpu_double_speed_d;
    logic        ack_q;
    logic [31:0] rdata_q;

    // Reset images; undefined documented bits are taken as zero
    localparam logic [7:0] AUX_RST = `DDPS_AUX_RESET;
    localparam logic [7:0] CLK_RST = `DDPS_CLK_RESET;

    function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
        hit = (adr[9:2] == idx);
    endfunction

    wire         req      = wb_cyc_i && wb_stb_i && !ack_q;
    wire         wr_lo    = req && wb_we_i && wb_sel_i[0];
    wire         wr_hi    = req && wb_we_i && wb_sel_i[1];
    wire         hit_aux  = hit(wb_adr_i, `DDPS_AUX_IDX);
    wire         hit_clk  = hit(wb_adr_i, `DDPS_CLK_IDX);
    wire         hit_p0   = hit(wb_adr_i, `DDPS_DPTR0_IDX);
    wire         hit_p1   = hit(wb_adr_i, `DDPS_DPTR1_IDX);
    wire         hit_mode = hit(wb_adr_i, `DDPS_MODE_IDX);

    // Bit two and reserved bits are built as constant zero
    wire [7:0]   aux_rd   = {2'b00, aux_q.boot_rom_map_en, 1'b0,
                             aux_q.user_flag_three, 1'b0, 1'b0, aux_q.pointer_select};
    // Increment of the read image: with bit one zero the carry stops there, so of the stored fields only bit zero flips
    wire [7:0]   aux_inc  = aux_rd + 8'h01;

    wire         sel      = aux_q.pointer_select;
    wire [15:0]  active   = sel ? ptrs_q.ptr1 : ptrs_q.ptr0;

    wire [31:0]  rd_mux   = hit_aux  ? {24'h0000_00, aux_rd} :
                            hit_clk  ? {31'h0000_0000, spi_rate_select_q} :
                            hit_p0   ? {16'h0000, ptrs_q.ptr0} :
                            hit_p1   ? {16'h0000, ptrs_q.ptr1} :
                            hit_mode ? {31'h0000_0000, cpu_double_speed_q} :
                                       32'h0000_0000;

    always_comb begin
        aux_d = aux_q;
        if (wr_lo && hit_aux) begin
            aux_d.pointer_select  = wb_dat_i[`DDPS_AUX_SEL_BIT];
            aux_d.user_flag_three = wb_dat_i[`DDPS_AUX_FLAG_BIT];
            aux_d.boot_rom_map_en = wb_dat_i[`DDPS_AUX_BOOT_BIT];
        end else if (aux_inc_i) begin
            aux_d.pointer_select  = aux_inc[`DDPS_AUX_SEL_BIT];
            aux_d.user_flag_three = aux_inc[`DDPS_AUX_FLAG_BIT];
            aux_d.boot_rom_map_en = aux_inc[`DDPS_AUX_BOOT_BIT];
        end
    end

    always_comb begin
        ptrs_d = ptrs_q;
        if (wr_lo && hit_p0) begin
            ptrs_d.ptr0[7:0] = wb_dat_i[7:0];
        end
        if (wr_hi && hit_p0) begin
            ptrs_d.ptr0[15:8] = wb_dat_i[15:8];
        end
        if (wr_lo && hit_p1) begin
            ptrs_d.ptr1[7:0] = wb_dat_i[7:0];
        end
        if (wr_hi && hit_p1) begin
            ptrs_d.ptr1[15:8] = wb_dat_i[15:8];
        end
        // Core access works only on the selected pointer and wins over the bus
        if (ptr_load_i || ptr_inc_i) begin
            if (sel) begin
                ptrs_d.ptr1 = ptr_load_i ? ptr_load_val_i : ptrs_q.ptr1 + 16'h0001;
            end else begin
                ptrs_d.ptr0 = ptr_load_i ? ptr_load_val_i : ptrs_q.ptr0 + 16'h0001;
            end
        end
    end

    assign spi_rate_select_d  = (wr_lo && hit_clk) ? wb_dat_i[`DDPS_CLK_SPI_BIT] : spi_rate_select_q;
    assign cpu_double_speed_d = (wr_lo && hit_mode) ? wb_dat_i[`DDPS_MODE_X2_BIT] : cpu_double_speed_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aux_q.pointer_select  <= AUX_RST[`DDPS_AUX_SEL_BIT];
            aux_q.user_flag_three <= AUX_RST[`DDPS_AUX_FLAG_BIT];
            aux_q.boot_rom_map_en <= AUX_RST[`DDPS_AUX_BOOT_BIT];
            ptrs_q             <= {`DDPS_PTR_RESET, `DDPS_PTR_RESET};
            spi_rate_select_q  <= CLK_RST[`DDPS_CLK_SPI_BIT];
            cpu_double_speed_q <= 1'b0;
        end else begin
            aux_q              <= aux_d;
            ptrs_q             <= ptrs_d;
            spi_rate_select_q  <= spi_rate_select_d;
            cpu_double_speed_q <= cpu_double_speed_d;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req;
            rdata_q <= req ? rd_mux : rdata_q;
        end
    end

    assign wb_ack_o               = ack_q;
    assign wb_dat_o               = rdata_q;
    assign data_pointer_o         = active;
    assign boot_rom_map_en_o      = aux_q.boot_rom_map_en;
    assign boot_rom_hit_o         = aux_q.boot_rom_map_en && (code_addr_i >= `DDPS_BOOT_BASE);
    assign cpu_double_speed_o     = cpu_double_speed_q;
    assign cpu_clocks_per_cycle_o = cpu_double_speed_q ? `DDPS_CLK_FAST : `DDPS_CLK_SLOW;
    assign spi_clocks_per_cycle_o = (cpu_double_speed_q && !spi_rate_select_q) ? `DDPS_CLK_FAST
                                                                              : `DDPS_CLK_SLOW;

    sel_toggle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (aux_inc_i && !(wr_lo && hit_aux)) |=> (aux_q.pointer_select != $past(aux_q.pointer_select))
            && (aux_q.user_flag_three == $past(aux_q.user_flag_three)))
        else $error("increment did not toggle select only");

    bit_two_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (req && !wb_we_i && hit_aux) |=> (wb_ack_o && wb_dat_o[`DDPS_AUX_ZERO_BIT] == 1'b0))
        else $error("aux bit two read non-zero");

    ptr_route_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        data_pointer_o == (aux_q.pointer_select ? ptrs_q.ptr1 : ptrs_q.ptr0))
        else $error("wrong pointer routed");

    ptr_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (ptr_inc_i && !ptr_load_i && !aux_q.pointer_select && !wr_lo && !wr_hi)
            |=> (ptrs_q.ptr0 == $past(ptrs_q.ptr0) + 16'h0001) && (ptrs_q.ptr1 == $past(ptrs_q.ptr1)))
        else $error("unselected pointer changed");

    boot_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        boot_rom_hit_o == (aux_q.boot_rom_map_en && code_addr_i >= 16'hF800))
        else $error("boot map window wrong");

    flag_store_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_lo && hit_aux) |=> (aux_q.user_flag_three == $past(wb_dat_i[3])))
        else $error("user flag not stored");

    spi_rate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (!cpu_double_speed_q |-> spi_clocks_per_cycle_o == 4'hC)
            and (cpu_double_speed_q && !spi_rate_select_q |-> spi_clocks_per_cycle_o == 4'h6))
        else $error("spi rate wrong");

    cpu_rate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cpu_clocks_per_cycle_o == (cpu_double_speed_q ? 4'h6 : 4'hC))
        else $error("cpu rate wrong");

    reset_clear_a: assert property (@(posedge clk_i)
        $rose(reset_n_i) |-> (!aux_q.pointer_select && !spi_rate_select_q))
        else $error("reset values wrong");

    ack_once_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    // Bus handshake: one answer per taken request, nothing else
    ack_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        req |=> wb_ack_o)
        else $error("request not answered");

    ack_cause_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");

    ack_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack while bus idle");

    rdata_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !req |=> $stable(wb_dat_o))
        else $error("read data moved without request");

    // Read images of each register except the mode register
    aux_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (req && !wb_we_i && hit_aux)
            |=> (wb_dat_o[31:6] == 26'h000_0000) && (wb_dat_o[4] == 1'b0) && (wb_dat_o[1] == 1'b0))
        else $error("aux reserved bits not zero");

    aux_fields_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (req && !wb_we_i && hit_aux)
            |=> (wb_dat_o[0] == $past(aux_q.pointer_select)) && (wb_dat_o[3] == $past(aux_q.user_flag_three))
                && (wb_dat_o[5] == $past(aux_q.boot_rom_map_en)))
        else $error("aux field read wrong");

    clk_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (req && !wb_we_i && hit_clk)
            |=> (wb_dat_o[31:1] == 31'h0000_0000) && (wb_dat_o[0] == $past(spi_rate_select_q)))
        else $error("spi clock register read wrong");

    p0_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (req && !wb_we_i && hit_p0) |=> wb_dat_o == {16'h0000, $past(ptrs_q.ptr0)})
        else $error("first pointer read wrong");

    p1_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (req && !wb_we_i && hit_p1) |=> wb_dat_o == {16'h0000, $past(ptrs_q.ptr1)})
        else $error("second pointer read wrong");

    unmapped_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (req && !hit_aux && !hit_clk && !hit_p0 && !hit_p1 && !hit_mode) |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Aux register updates
    sel_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_lo && hit_aux) |=> aux_q.pointer_select == $past(wb_dat_i[0]))
        else $error("select not stored");

    boot_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_lo && hit_aux) |=> aux_q.boot_rom_map_en == $past(wb_dat_i[5]))
        else $error("boot enable not stored");

    aux_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (!aux_inc_i && !(wr_lo && hit_aux)) |=> $stable(aux_q))
        else $error("aux changed with no cause");

    inc_boot_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (aux_inc_i && !(wr_lo && hit_aux)) |=> $stable(aux_q.boot_rom_map_en))
        else $error("increment disturbed boot enable");

    // Clock control updates and derived rates
    spi_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_lo && hit_clk) |=> spi_rate_select_q == $past(wb_dat_i[0]))
        else $error("spi rate bit not stored");

    spi_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(wr_lo && hit_clk) |=> $stable(spi_rate_select_q))
        else $error("spi rate bit changed");

    spi_slow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (cpu_double_speed_q && spi_rate_select_q) |-> spi_clocks_per_cycle_o == 4'hC)
        else $error("spi slow rate wrong");

    spi_nox2_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !cpu_double_speed_o |-> spi_clocks_per_cycle_o == 4'hC)
        else $error("spi rate without double speed");

    mode_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_lo && hit_mode) |=> cpu_double_speed_o == $past(wb_dat_i[0]))
        else $error("double speed not stored");

    // Pointer updates
    load_p0_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (ptr_load_i && !aux_q.pointer_select)
            |=> (ptrs_q.ptr0 == $past(ptr_load_val_i)) && $stable(ptrs_q.ptr1))
        else $error("first pointer load wrong");

    load_p1_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (ptr_load_i && aux_q.pointer_select)
            |=> (ptrs_q.ptr1 == $past(ptr_load_val_i)) && $stable(ptrs_q.ptr0))
        else $error("second pointer load wrong");

    inc_p1_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (ptr_inc_i && !ptr_load_i && aux_q.pointer_select && !wr_lo && !wr_hi)
            |=> (ptrs_q.ptr1 == $past(ptrs_q.ptr1) + 16'h0001) && $stable(ptrs_q.ptr0))
        else $error("second pointer increment wrong");

    lane_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_lo && hit_p1 && !ptr_load_i && !ptr_inc_i)
            |=> ptrs_q.ptr1[7:0] == $past(wb_dat_i[7:0]))
        else $error("pointer low byte not stored");

    lane_keep_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_lo && !wr_hi && hit_p1 && !ptr_load_i && !ptr_inc_i)
            |=> ptrs_q.ptr1[15:8] == $past(ptrs_q.ptr1[15:8]))
        else $error("unselected pointer lane changed");

    ptr_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (!ptr_load_i && !ptr_inc_i && !wr_lo && !wr_hi) |=> $stable(ptrs_q))
        else $error("pointers changed with no cause");

    // Boot map window
    boot_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !boot_rom_map_en_o |-> !boot_rom_hit_o)
        else $error("boot hit while disabled");

    boot_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (code_addr_i < 16'hF800) |-> !boot_rom_hit_o)
        else $error("boot hit below window");

    // State just after reset
    reset_ptr_a: assert property (@(posedge clk_i)
        $rose(reset_n_i) |-> (ptrs_q == 32'h0000_0000) && !cpu_double_speed_q && !wb_ack_o)
        else $error("pointers or ack not cleared");

endmodule // ddps_top

`default_nettype wire

// File: tb/tb_ddps_top.sv
/* Self-checking bench for ddps_top: Wishbone register traffic, core pointer ops, boot map, clock rates.
   Assumes the word-per-register map and one-cycle registered ack of the design. */
`timescale 1ns/1ps
`default_nettype none
`include "ddps_regs.svh"
module tb_ddps_top import ddps_pkg::*; ;
    localparam logic [9:0] AUX = {`DDPS_AUX_IDX, 2'b00};
    localparam logic [9:0] CLK = {`DDPS_CLK_IDX, 2'b00};
    localparam logic [9:0] PT0 = {`DDPS_DPTR0_IDX, 2'b00};
    localparam logic [9:0] PT1 = {`DDPS_DPTR1_IDX, 2'b00};
    localparam logic [9:0] MOD = {`DDPS_MODE_IDX, 2'b00};
    logic        clk_i = 1'b0, reset_n_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        aux_inc_i = 1'b0, ptr_load_i = 1'b0, ptr_inc_i = 1'b0;
    logic [15:0] ptr_load_val_i = 16'h0000, code_addr_i = 16'h0000, data_pointer_o, v;
    logic        boot_rom_map_en_o, boot_rom_hit_o, cpu_double_speed_o;
    logic [3:0]  cpu_clocks_per_cycle_o, spi_clocks_per_cycle_o;
    int          error_cnt = 0;
    int          n_tests = 0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    ddps_ptrs_t  ptrs;
    ddps_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .aux_inc_i(aux_inc_i), .ptr_load_i(ptr_load_i), .ptr_load_val_i(ptr_load_val_i),
        .ptr_inc_i(ptr_inc_i), .code_addr_i(code_addr_i), .data_pointer_o(data_pointer_o),
        .boot_rom_map_en_o(boot_rom_map_en_o), .boot_rom_hit_o(boot_rom_hit_o),
        .cpu_double_speed_o(cpu_double_speed_o), .cpu_clocks_per_cycle_o(cpu_clocks_per_cycle_o),
        .spi_clocks_per_cycle_o(spi_clocks_per_cycle_o));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Classic single cycle; expected read image noted before the request goes out
    task automatic wb(input logic we, input logic [9:0] adr, input logic [31:0] dat, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic core(input logic inc, input logic ld, input logic pinc);
        @(posedge clk_i);
        aux_inc_i  <= inc;
        ptr_load_i <= ld;
        ptr_inc_i  <= pinc;
        @(posedge clk_i);
        aux_inc_i  <= 1'b0;
        ptr_load_i <= 1'b0;
        ptr_inc_i  <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic boot(input logic en);
        foreach (ptrs.ptr0[i]) if (i < 3) begin
            @(posedge clk_i);
            code_addr_i <= (i == 0) ? 16'hF7FF : ((i == 1) ? `DDPS_BOOT_BASE : 16'hFFFF);
            @(negedge clk_i);
            check("boot_hit", 32'(boot_rom_hit_o), 32'(en && i != 0));
        end
    endtask
    // Write results carry mask zero, so only reads are really compared
    always @(posedge clk_i) begin : mon
        logic [31:0] e, m;
        if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check("wb_dat_o", wb_dat_o & m, e);
        end
    end
    initial begin
        #(50 * 5000);
        error_cnt++;
        finish_test();
    end
    initial begin
        void'($urandom(43906));
        ptrs = {16'($urandom), 16'($urandom)};
        v = 16'($urandom);
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        check("spi_clk", 32'(spi_clocks_per_cycle_o), 32'd12);
        wb(0, AUX, 0, 32'h0, 32'h05);
        wb(0, CLK, 0, 32'h0, 32'h01);
        wb(0, 10'h3FC, 0, 32'h0, 32'hFFFF_FFFF);
        wb(1, AUX, 32'h2D, 0, 0);
        wb(0, AUX, 0, 32'h29, 32'h2D);
        check("boot_en", 32'(boot_rom_map_en_o), 32'd1);
        boot(1'b1);
        core(1, 0, 0);
        wb(0, AUX, 0, 32'h28, 32'h2D);
        core(1, 0, 0);
        wb(0, AUX, 0, 32'h29, 32'h2D);
        wb(1, PT0, 32'(ptrs.ptr0), 0, 0);
        wb(1, PT1, 32'(ptrs.ptr1), 0, 0);
        check("data_pointer_sel1", 32'(data_pointer_o), 32'(ptrs.ptr1));
        wb(1, AUX, 32'h00, 0, 0);
        check("data_pointer_sel0", 32'(data_pointer_o), 32'(ptrs.ptr0));
        check("boot_dis", 32'(boot_rom_map_en_o), 32'd0);
        boot(1'b0);
        ptr_load_val_i <= v;
        core(0, 1, 0);
        core(0, 0, 1);
        check("data_pointer_ld_inc", 32'(data_pointer_o), 32'(v + 16'h0001));
        core(1, 0, 0);
        check("data_pointer_other", 32'(data_pointer_o), 32'(ptrs.ptr1));
        @(posedge clk_i);
        wb_sel_i <= 4'h1;
        wb(1, PT1, 32'(~ptrs.ptr1), 0, 0);
        wb(0, PT1, 0, 32'({ptrs.ptr1[15:8], ~ptrs.ptr1[7:0]}), 32'h0000_FFFF);
        check("data_pointer_lane", 32'(data_pointer_o), 32'({ptrs.ptr1[15:8], ~ptrs.ptr1[7:0]}));
        @(posedge clk_i);
        wb_sel_i <= 4'hF;
        wb(0, PT0, 0, 32'(v + 16'h0001), 32'h0000_FFFF);
        for (int i = 0; i < 4; i++) begin
            wb(1, MOD, 32'(i >> 1), 0, 0);
            wb(1, CLK, 32'(i & 1), 0, 0);
            check("cpu_x2", 32'(cpu_double_speed_o), 32'(i >> 1));
            check("cpu_clk", 32'(cpu_clocks_per_cycle_o), (i >> 1) ? 32'd6 : 32'd12);
            check("spi_clk", 32'(spi_clocks_per_cycle_o), (i == 2) ? 32'd6 : 32'd12);
        end
        // Mid-run reset must bring select, first pointer and SPI rate bit back
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(negedge clk_i);
        check("data_pointer_rst", 32'(data_pointer_o), 32'h0);
        check("spi_rst", 32'(spi_clocks_per_cycle_o), 32'd12);
        wb(0, AUX, 0, 32'h0, 32'h05);
        wb(0, CLK, 0, 32'h0, 32'h01);
        finish_test();
    end
endmodule // tb_ddps_top
`default_nettype wire
